// *** design/auto_retry_ack_config.sv ***
// retry limits, slotted acknowledge, backoff seed and acknowledge filter bank
// assumes mac engine events are one-cycle pulses on i_clk; trigger pin is asynchronous
`timescale 1ns/1ps
`default_nettype none
module auto_retry_ack_config (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // register port
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    // trigger pin and sleep wake
    input wire logic i_sleep_tx_trigger_pin,
    input wire logic i_wake_deepest_sleep,
    // retransmit transaction events
    input wire logic i_tx_start,
    input wire logic i_csma_busy,
    input wire logic i_csma_clear,
    input wire logic i_ack_received,
    input wire logic i_ack_timeout,
    output logic o_csma_run,
    output logic o_tx_send,
    output logic o_tx_cancel,
    output logic [2:0] o_transaction_result,
    // received frame description
    input wire logic i_rx_done,
    input wire logic [1:0] i_rx_version,
    input wire logic i_rx_ack_req,
    input wire logic i_rx_data_req,
    input wire logic i_rx_data_or_cmd,
    input wire logic i_rx_src_only,
    input wire logic i_rx_src_pan_match,
    output logic o_rx_accept,
    output logic o_rx_reject,
    // acknowledgement frame
    output logic o_ack_send,
    output logic o_ack_pending,
    output logic [1:0] o_ack_version,
    // backoff generator
    output logic [10:0] o_backoff_rand
);
    import retry_ack_pkg::*;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_CSMA = 2'b01,
        TX_WAIT_ACK = 2'b10
    } tx_state_t;

    // ****************************************************************
    // register bank
    // ****************************************************************
    logic [7:0] retry_ctrl_q, seed_low_q, seed_high_q;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            retry_ctrl_q <= RST_RETRY_CTRL;
            seed_low_q <= RST_SEED_LOW;
            seed_high_q <= RST_SEED_HIGH;
        end else if (i_reg_wr) begin
            if (i_reg_addr == ADDR_RETRY_CTRL) retry_ctrl_q <= i_reg_wdata;
            if (i_reg_addr == ADDR_SEED_LOW) seed_low_q <= i_reg_wdata;
            if (i_reg_addr == ADDR_SEED_HIGH) seed_high_q <= i_reg_wdata;
        end
    end

    // read data one cycle after the address; unmapped offsets read zero
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_reg_rdata <= 8'h00;
        end else begin
            unique case (i_reg_addr)
                ADDR_RETRY_CTRL: o_reg_rdata <= retry_ctrl_q;
                ADDR_SEED_LOW: o_reg_rdata <= seed_low_q;
                ADDR_SEED_HIGH: o_reg_rdata <= seed_high_q;
                default: o_reg_rdata <= 8'h00;
            endcase
        end
    end

    logic [3:0] frame_limit;
    logic [2:0] access_limit;
    logic slotted, pend_val, suppress, coord;
    logic [1:0] version_filter;
    logic [SEED_WIDTH-1:0] seed;

    assign frame_limit = retry_ctrl_q[FRAME_LIMIT_LSB +: 4];
    assign access_limit = retry_ctrl_q[ACCESS_LIMIT_LSB +: 3];
    assign slotted = retry_ctrl_q[SLOTTED_BIT];
    assign version_filter = seed_high_q[VERSION_FILTER_LSB +: 2];
    assign pend_val = seed_high_q[PENDING_BIT];
    assign suppress = seed_high_q[SUPPRESS_BIT];
    assign coord = seed_high_q[COORD_BIT];
    assign seed = {seed_high_q[SEED_HIGH_LSB +: 3], seed_low_q};

    // ****************************************************************
    // backoff generator, reloaded on wake from deepest sleep
    // ****************************************************************
    backoff_lfsr #(.WIDTH(SEED_WIDTH)) u_lfsr (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_load(i_wake_deepest_sleep),
        .i_seed(seed),
        .i_rst_seed(seed),
        .o_value(o_backoff_rand)
    );

    // ****************************************************************
    // retransmit transaction control
    // ****************************************************************
    tx_state_t tx_state_q;
    logic [3:0] frame_cnt_q;
    logic [2:0] csma_cnt_q;
    logic immediate;
    logic [2:0] tx_result_d;
    logic tx_result_set;

    assign immediate = (access_limit == ACCESS_IMMEDIATE);

    // a start always restarts cleanly, even in the middle of a transaction
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            tx_state_q <= TX_IDLE;
            frame_cnt_q <= 4'h0;
            csma_cnt_q <= 3'h0;
            o_csma_run <= 1'b0;
            o_tx_send <= 1'b0;
            o_tx_cancel <= 1'b0;
            tx_result_set <= 1'b0;
            tx_result_d <= RES_IDLE;
        end else begin
            o_csma_run <= 1'b0;
            o_tx_send <= 1'b0;
            o_tx_cancel <= 1'b0;
            tx_result_set <= 1'b0;
            if (i_tx_start) begin
                frame_cnt_q <= 4'h0;
                csma_cnt_q <= 3'h0;
                o_tx_send <= immediate;
                o_csma_run <= !immediate;
                tx_state_q <= immediate ? TX_WAIT_ACK : TX_CSMA;
            end else begin
                unique case (tx_state_q)
                    TX_IDLE: ;
                    TX_CSMA: begin
                        if (i_csma_clear) begin
                            o_tx_send <= 1'b1;
                            tx_state_q <= TX_WAIT_ACK;
                        end else if (i_csma_busy) begin
                            if (csma_cnt_q >= access_limit) begin
                                o_tx_cancel <= 1'b1;
                                tx_result_set <= 1'b1;
                                tx_result_d <= RES_ACCESS_FAILURE;
                                tx_state_q <= TX_IDLE;
                            end else begin
                                csma_cnt_q <= csma_cnt_q + 3'h1;
                                o_csma_run <= 1'b1;
                            end
                        end
                    end
                    TX_WAIT_ACK: begin
                        if (i_ack_received) begin
                            tx_result_set <= 1'b1;
                            tx_result_d <= RES_SUCCESS;
                            tx_state_q <= TX_IDLE;
                        end else if (i_ack_timeout) begin
                            if (frame_cnt_q >= frame_limit) begin
                                o_tx_cancel <= 1'b1;
                                tx_result_set <= 1'b1;
                                tx_result_d <= RES_NO_ACK;
                                tx_state_q <= TX_IDLE;
                            end else begin
                                // each resend gets a fresh channel access budget
                                frame_cnt_q <= frame_cnt_q + 4'h1;
                                csma_cnt_q <= 3'h0;
                                o_tx_send <= immediate;
                                o_csma_run <= !immediate;
                                tx_state_q <= immediate ? TX_WAIT_ACK : TX_CSMA;
                            end
                        end
                    end
                    default: tx_state_q <= TX_IDLE;
                endcase
            end
        end
    end

    // ****************************************************************
    // trigger pin synchroniser and rising edge
    // ****************************************************************
    logic trig_meta_q, trig_sync_q, trig_prev_q, trig_rise;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            trig_meta_q <= 1'b0;
            trig_sync_q <= 1'b0;
            trig_prev_q <= 1'b0;
        end else begin
            trig_meta_q <= i_sleep_tx_trigger_pin;
            trig_sync_q <= trig_meta_q;
            trig_prev_q <= trig_sync_q;
        end
    end

    assign trig_rise = trig_sync_q & ~trig_prev_q;

    // ****************************************************************
    // receive filter and acknowledgement
    // ****************************************************************
    function automatic logic version_ok(input logic [1:0] filt, input logic [1:0] ver);
        version_ok = (filt == 2'h3) || (ver <= filt);
    endfunction

    logic rx_pass, ack_wanted, ack_wait_q, ack_pend_hold_q;

    assign rx_pass = version_ok(version_filter, i_rx_version)
        && !(coord && i_rx_data_or_cmd && i_rx_src_only && !i_rx_src_pan_match);
    assign ack_wanted = rx_pass && i_rx_ack_req && !suppress;

    // a new frame while an acknowledgement is held is filtered but not answered
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_rx_accept <= 1'b0;
            o_rx_reject <= 1'b0;
            o_ack_send <= 1'b0;
            o_ack_pending <= 1'b0;
            o_ack_version <= 2'h0;
            ack_wait_q <= 1'b0;
            ack_pend_hold_q <= 1'b0;
        end else begin
            o_rx_accept <= i_rx_done && rx_pass;
            o_rx_reject <= i_rx_done && !rx_pass;
            o_ack_send <= 1'b0;
            o_ack_version <= 2'h0;
            if (ack_wait_q) begin
                if (trig_rise) begin
                    ack_wait_q <= 1'b0;
                    o_ack_send <= 1'b1;
                    o_ack_pending <= ack_pend_hold_q;
                end
            end else if (i_rx_done && ack_wanted) begin
                if (slotted) begin
                    ack_wait_q <= 1'b1;
                    ack_pend_hold_q <= i_rx_data_req && pend_val;
                end else begin
                    o_ack_send <= 1'b1;
                    o_ack_pending <= i_rx_data_req && pend_val;
                end
            end
        end
    end

    // ****************************************************************
    // transaction result: the held acknowledgement takes precedence
    // ****************************************************************
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_transaction_result <= RES_IDLE;
        end else if (!ack_wait_q && i_rx_done && ack_wanted && slotted) begin
            o_transaction_result <= RES_WAIT_FOR_ACK_TRIGGER;
        end else if (ack_wait_q && trig_rise) begin
            o_transaction_result <= RES_SUCCESS;
        end else if (tx_result_set && !ack_wait_q) begin
            o_transaction_result <= tx_result_d;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    chk_frame_limit: assert property (@(posedge i_clk) disable iff (i_rst)
        (tx_state_q == TX_WAIT_ACK && !i_tx_start && !i_ack_received && i_ack_timeout
            && frame_cnt_q == frame_limit) |=> o_tx_cancel ##1 tx_result_set == 1'b0)
        else $error("frame retry limit did not cancel");
    chk_access_limit: assert property (@(posedge i_clk) disable iff (i_rst)
        (tx_state_q == TX_CSMA && !i_tx_start && !i_csma_clear && i_csma_busy
            && csma_cnt_q < access_limit) |=> o_csma_run && !o_tx_cancel)
        else $error("access retry cancelled early");
    chk_immediate_send: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_tx_start && access_limit == ACCESS_IMMEDIATE) |=> o_tx_send && !o_csma_run)
        else $error("immediate send missing");
    chk_unslotted_ack: assert property (@(posedge i_clk) disable iff (i_rst)
        (!ack_wait_q && i_rx_done && ack_wanted && !slotted) |=> o_ack_send)
        else $error("unslotted ack not sent");
    chk_slot_hold: assert property (@(posedge i_clk) disable iff (i_rst)
        (ack_wait_q && !trig_rise) |=> !o_ack_send && ack_wait_q)
        else $error("ack left hold without trigger");
    chk_wait_code: assert property (@(posedge i_clk) disable iff (i_rst)
        ack_wait_q |-> o_transaction_result == RES_WAIT_FOR_ACK_TRIGGER)
        else $error("wait code not shown");
    chk_seed_load: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_wake_deepest_sleep && seed != '0) |=> o_backoff_rand == $past(seed))
        else $error("seed not loaded on wake");
    chk_version_reject: assert property (@(posedge i_clk) disable iff (i_rst)
        (!ack_wait_q && i_rx_done && version_filter != 2'h3 && i_rx_version > version_filter)
            |=> o_rx_reject && !o_ack_send ##1 !o_ack_send)
        else $error("high version not rejected");
    chk_ack_suppress: assert property (@(posedge i_clk) disable iff (i_rst)
        (!ack_wait_q && i_rx_done && suppress) |=> !o_ack_send && !ack_wait_q)
        else $error("suppressed ack sent");
    chk_counter_clear: assert property (@(posedge i_clk) disable iff (i_rst)
        i_tx_start |=> frame_cnt_q == 4'h0 && csma_cnt_q == 3'h0)
        else $error("retry counters not cleared");
endmodule // auto_retry_ack_config
`default_nettype wire

// *** design/retry_ack_pkg.sv ***
// package of constants for the retry, acknowledge and backoff seed register bank
// assumes one clock domain and a simple byte-wide register port on the device side
//
// Summary of operation
// - unacknowledged frame is resent at most frame-retry-limit times, then cancelled
// - channel access retried access-retry-limit times (0..5) before cancel; 6 is reserved, but the code treats 6 as a limit of six retries
// - access retry limit 7 sends the frame at once with no channel access; frame retries still apply
// - slotted select 0 sends a requested acknowledgement automatically
// - slotted select 1 holds the acknowledgement until a trigger pin rising edge
// - while holding the acknowledgement the result field shows the wait-for-trigger code
// - 11-bit backoff seed is low register plus high register bits 2:0 as bits 10:8
// - backoff generator reloads from the seed registers on wake from deepest sleep
// - version filter 0,1,2 accept versions up to that value; 3 accepts any
// - frames above the configured version fail the filter and are not acknowledged
// - every generated acknowledgement carries frame version zero
// - acknowledge suppress bit set means no acknowledgement is sent, except one already held for the trigger pin
// - pending bit value is copied into acknowledgements of data request commands
// - coordinator role rejects source-only data or command frames whose source PAN does not match
package retry_ack_pkg;

    // ****************************************************************
    // register offsets and reset values
    // ****************************************************************
    localparam logic [7:0] ADDR_RETRY_CTRL = 8'h2C;
    localparam logic [7:0] ADDR_SEED_LOW = 8'h2D;
    localparam logic [7:0] ADDR_SEED_HIGH = 8'h2E;
    localparam logic [7:0] RST_RETRY_CTRL = 8'h38;
    localparam logic [7:0] RST_SEED_LOW = 8'hEA;
    localparam logic [7:0] RST_SEED_HIGH = 8'h42;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int FRAME_LIMIT_LSB = 4;
    localparam int ACCESS_LIMIT_LSB = 1;
    localparam int SLOTTED_BIT = 0;
    localparam int VERSION_FILTER_LSB = 6;
    localparam int PENDING_BIT = 5;
    localparam int SUPPRESS_BIT = 4;
    localparam int COORD_BIT = 3;
    localparam int SEED_HIGH_LSB = 0;
    localparam int SEED_WIDTH = 11;

    // access limit code that skips channel access
    localparam logic [2:0] ACCESS_IMMEDIATE = 3'h7;
    // replacement seed for the all-zero lockup value of the generator
    localparam logic [10:0] SEED_NONZERO = 11'h001;

    // ****************************************************************
    // transaction result codes
    // ****************************************************************
    localparam logic [2:0] RES_SUCCESS = 3'h0;
    localparam logic [2:0] RES_WAIT_FOR_ACK_TRIGGER = 3'h2;
    localparam logic [2:0] RES_ACCESS_FAILURE = 3'h3;
    localparam logic [2:0] RES_NO_ACK = 3'h5;
    localparam logic [2:0] RES_IDLE = 3'h7;

endpackage

// *** design/backoff_lfsr.sv ***
// random backoff generator: 11-bit linear feedback shift register
// assumes the seed input is stable in the cycle that load is high
`timescale 1ns/1ps
`default_nettype none
module backoff_lfsr #(
    parameter int WIDTH = 11
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // seed load
    input wire logic i_load,
    input wire logic [WIDTH-1:0] i_seed,
    input wire logic [WIDTH-1:0] i_rst_seed,
    // generator state
    output logic [WIDTH-1:0] o_value
);
    // ****************************************************************
    // shift register, x^11 + x^9 + 1, advances every cycle
    // ****************************************************************
    logic [WIDTH-1:0] lfsr_q;
    logic feedback;

    assign feedback = lfsr_q[WIDTH-1] ^ lfsr_q[WIDTH-3];

    // a zero seed would lock the register, so it is replaced by one
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            lfsr_q <= '1;
        end else if (i_load) begin
            lfsr_q <= (i_seed == '0) ? {{(WIDTH-1){1'b0}}, 1'b1} : i_seed;
        end else begin
            lfsr_q <= {lfsr_q[WIDTH-2:0], feedback};
        end
    end

    assign o_value = lfsr_q;

    // unused: reset loads all ones, and the parent brings the seed in only through the load path on wake
    logic unused_rst_seed;
    assign unused_rst_seed = ^i_rst_seed;
endmodule // backoff_lfsr
`default_nettype wire

// *** bench/host_model.sv ***
// host model: writes and reads the register bank and drives the trigger pin
// assumes one caller at a time; every change lands just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module host_model (
    // clock
    input wire logic i_clk,
    // register port towards the device
    output logic [7:0] o_reg_addr,
    output logic o_reg_wr,
    output logic [7:0] o_reg_wdata,
    // trigger pin
    output logic o_trigger
);
    initial begin
        o_reg_addr = 8'h00;
        o_reg_wr = 1'b0;
        o_reg_wdata = 8'h00;
        o_trigger = 1'b0;
    end

    // one-cycle write strobe; data is inverted after release so no stale byte lingers
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_reg_addr <= a;
        o_reg_wdata <= d;
        o_reg_wr <= 1'b1;
        @(posedge i_clk);
        o_reg_wr <= 1'b0;
        o_reg_wdata <= ~d;
    endtask

    // present an address, return once the registered answer has settled
    task automatic rd(input logic [7:0] a);
        @(posedge i_clk);
        o_reg_addr <= a;
        @(posedge i_clk);
        #1;
    endtask

    // pin level after a chosen number of cycles, so the host can be prompt or slow
    task automatic pin(input logic lvl, input int dly);
        repeat (dly) @(posedge i_clk);
        o_trigger <= lvl;
    endtask
endmodule // host_model
`default_nettype wire

// *** bench/auto_retry_ack_config_bench.sv ***
// self-checking bench for the retry, acknowledge and backoff seed bank
// assumes host_model owns the register port and trigger pin; bench drives mac events
`timescale 1ns/1ps
`default_nettype none
module auto_retry_ack_config_bench;
    import retry_ack_pkg::*;
    // one retransmit case: control byte, channel busy, ack arrives, expected counts
    typedef struct {
        logic [7:0] ctrl;
        logic busy;
        logic ack;
        int runs;
        int sends;
        logic [2:0] res;
    } tx_row_t;
    tx_row_t rows [9] = '{'{8'h38, 1, 0, 5, 0, 3'h3}, '{8'h38, 1, 0, 5, 0, 3'h3},
        '{8'h30, 1, 0, 1, 0, 3'h3}, '{8'h3A, 1, 0, 6, 0, 3'h3}, '{8'h2E, 0, 0, 0, 3, 3'h5},
        '{8'h0E, 0, 0, 0, 1, 3'h5}, '{8'h7E, 0, 0, 0, 8, 3'h5}, '{8'h10, 0, 0, 2, 2, 3'h5},
        '{8'h0E, 0, 1, 0, 1, 3'h0}};
    logic clk = 0, rst = 1, wake = 0, start = 0, busy = 0, clear = 0, ackr = 0, tmo = 0;
    logic rx_done = 0, busy_mode = 0, ack_mode = 0, ok, rx_dc = 1;
    logic [5:0] rx_bits = 6'h00; // version[5:4] ack_req data_req src_only pan_match
    logic [7:0] addr, wdata, rdata;
    logic wr, trig, run, send, cancel, accept, reject, ack_send, ack_pend;
    logic [2:0] result;
    logic [1:0] ack_ver;
    logic [10:0] rand_val;
    int num_errors = 0, n_compared = 0, runs = 0, sends = 0, cancels = 0, cycles = 0;

    always #50 clk = ~clk;

    host_model host (.i_clk(clk), .o_reg_addr(addr), .o_reg_wr(wr), .o_reg_wdata(wdata),
        .o_trigger(trig));
    auto_retry_ack_config DUT (.i_clk(clk), .i_rst(rst), .i_reg_addr(addr), .i_reg_wr(wr),
        .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_sleep_tx_trigger_pin(trig),
        .i_wake_deepest_sleep(wake), .i_tx_start(start), .i_csma_busy(busy),
        .i_csma_clear(clear), .i_ack_received(ackr), .i_ack_timeout(tmo), .o_csma_run(run),
        .o_tx_send(send), .o_tx_cancel(cancel), .o_transaction_result(result),
        .i_rx_done(rx_done), .i_rx_version(rx_bits[5:4]), .i_rx_ack_req(rx_bits[3]),
        .i_rx_data_req(rx_bits[2]), .i_rx_data_or_cmd(rx_dc), .i_rx_src_only(rx_bits[1]),
        .i_rx_src_pan_match(rx_bits[0]), .o_rx_accept(accept), .o_rx_reject(reject),
        .o_ack_send(ack_send), .o_ack_pending(ack_pend), .o_ack_version(ack_ver),
        .o_backoff_rand(rand_val));

    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic check(input logic [10:0] seen, input logic [10:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // one received frame; outputs are sampled once the answering edge has landed
    task automatic rx(input logic [5:0] b);
        @(posedge clk);
        rx_bits <= b;
        rx_done <= 1'b1;
        @(posedge clk);
        rx_done <= 1'b0;
        rx_bits <= ~b;
        #1;
    endtask

    // mac engine stand-in: answers each access run and send one cycle later, counts them
    always @(posedge clk) begin
        busy <= run & busy_mode;
        clear <= run & ~busy_mode;
        tmo <= send & ~ack_mode;
        ackr <= send & ack_mode;
        if (run === 1'b1) runs++;
        if (send === 1'b1) sends++;
        if (cancel === 1'b1) cancels++;
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            conclude();
        end
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        host.rd(ADDR_RETRY_CTRL);
        check(rdata, 8'h38);
        check(result, 3'h7);
        host.rd(ADDR_SEED_LOW);
        check(rdata, 8'hEA);
        host.rd(ADDR_SEED_HIGH);
        check(rdata, 8'h42);
        // retransmit rows; the repeated first row shows counters start afresh
        foreach (rows[i]) begin
            host.wr(ADDR_RETRY_CTRL, rows[i].ctrl);
            host.rd(ADDR_RETRY_CTRL);
            check(rdata, rows[i].ctrl);
            busy_mode = rows[i].busy;
            ack_mode = rows[i].ack;
            runs = 0;
            sends = 0;
            cancels = 0;
            @(posedge clk);
            start <= 1'b1;
            @(posedge clk);
            start <= 1'b0;
            repeat (40) @(posedge clk);
            #1;
            check(11'(runs), 11'(rows[i].runs));
            check(11'(sends), 11'(rows[i].sends));
            check(11'(cancels), {10'h000, rows[i].res != 3'h0});
            check(result, rows[i].res);
        end
        host.wr(8'h2F, 8'hFF);
        host.rd(8'h2F);
        check(rdata, 8'h00);
        host.wr(ADDR_RETRY_CTRL, 8'h38);
        // every filter code against every frame version, unslotted
        for (int f = 0; f < 4; f++) begin
            host.wr(ADDR_SEED_HIGH, {2'(f), 6'h02});
            for (int v = 0; v < 4; v++) begin
                rx({2'(v), 4'b1000});
                ok = (f == 3) || (v <= f);
                check(accept, ok);
                check(reject, !ok);
                check(ack_send, ok);
                check(ack_ver, 2'b00);
            end
        end
        // slotted: ack held until a slow host raises the pin
        host.wr(ADDR_SEED_HIGH, 8'h42);
        host.wr(ADDR_RETRY_CTRL, 8'h39);
        rx(6'b00_1000);
        check(accept, 1'b1);
        check(ack_send, 1'b0);
        repeat (4) begin
            @(posedge clk);
            #1;
            check(ack_send, 1'b0);
            check(result, 3'h2);
        end
        host.pin(1'b1, 3);
        sends = 0;
        repeat (6) begin
            @(posedge clk);
            #1;
            if (ack_send === 1'b1) sends++;
        end
        check(11'(sends), 11'h001);
        check(result, 3'h0);
        host.pin(1'b0, 1);
        // suppress, pending copy and coordinator filtering, unslotted again
        host.wr(ADDR_RETRY_CTRL, 8'h38);
        host.wr(ADDR_SEED_HIGH, 8'h52);
        rx(6'b00_1000);
        check(accept, 1'b1);
        check(ack_send, 1'b0);
        host.wr(ADDR_SEED_HIGH, 8'h62);
        rx(6'b00_1100);
        check(ack_send, 1'b1);
        check(ack_pend, 1'b1);
        rx(6'b00_1000);
        check(ack_pend, 1'b0);
        host.wr(ADDR_SEED_HIGH, 8'h4A);
        rx(6'b00_0010);
        check(reject, 1'b1);
        rx(6'b00_0011);
        check(accept, 1'b1);
        // source-only frame that is neither data nor command is not held to the PAN match
        @(posedge clk) rx_dc <= 1'b0;
        rx(6'b00_0010);
        check(accept, 1'b1);
        @(posedge clk) rx_dc <= 1'b1;
        // seed is loaded only on wake from the deepest sleep
        host.wr(ADDR_SEED_LOW, 8'h5A);
        host.wr(ADDR_SEED_HIGH, 8'h43);
        @(posedge clk);
        wake <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
        #1;
        check(rand_val, 11'h35A);
        // a second reset mid-run restores the seed byte and the idle result
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        host.rd(ADDR_SEED_LOW);
        check(rdata, 8'hEA);
        check(result, 3'h7);
        conclude();
    end
endmodule // auto_retry_ack_config_bench
`default_nettype wire
